// *** core/cur_key_mem.sv ***
// private key store: small word memory with registered read data
`default_nettype none
module cur_key_mem #(
  parameter int WORDS = 4,
  parameter int WIDTH = 32
) (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [$clog2(WORDS)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(WORDS)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [WORDS];

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule // cur_key_mem
`default_nettype wire

// *** core/cur_pkg.sv ***
// shared constants and carriers of the configuration update register bank
`default_nettype none
package cur_pkg;

  // ----------------------------------------------------------------------
  // memory pages (word index, byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PG_PROD_ID_LO   = 8'h06;
  localparam logic [7:0] PG_PROD_ID_HI   = 8'h07;
  localparam logic [7:0] PG_MAKER        = 8'h08;
  localparam logic [7:0] PG_NODE_ADDR    = 8'h0c;
  localparam logic [7:0] PG_PROT_FIRST   = 8'h0e;
  localparam logic [7:0] PG_CFG_VARIANT  = 8'h0e;
  localparam logic [7:0] PG_EXTRA_DATA   = 8'h0f;
  localparam logic [7:0] PG_PROD_STG_LO  = 8'h10;
  localparam logic [7:0] PG_PROD_STG_HI  = 8'h11;
  localparam logic [7:0] PG_ADDR_STG     = 8'h12;
  localparam logic [7:0] PG_MAKER_STG    = 8'h13;
  localparam logic [7:0] PG_KEY_STG_0    = 8'h14;
  localparam logic [7:0] PG_KEY_STG_3    = 8'h17;
  localparam logic [7:0] PG_USER_CHAN    = 8'h18;
  localparam logic [7:0] PG_PIN          = 8'he5;

  // ----------------------------------------------------------------------
  // config_flags field positions
  // ----------------------------------------------------------------------
  localparam int CFG_NODE_COMMIT   = 0;
  localparam int CFG_MAKER_COMMIT  = 1;
  localparam int CFG_KEY_COMMIT    = 2;
  localparam int CFG_KEY_HIDDEN    = 3;
  localparam int CFG_ROTATING_ADDR = 4;
  localparam int CFG_COMM_OFF      = 5;
  localparam int CFG_LEN_LSB       = 6;

  // ----------------------------------------------------------------------
  // radio_variant field positions
  // ----------------------------------------------------------------------
  localparam int VAR_PLAN_LSB  = 0;
  localparam int VAR_INTERVAL  = 3;
  localparam int VAR_RATE      = 4;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  VARIANT_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ      = 50000;
  localparam int REPEAT_LONG_MS    = 20;
  localparam int REPEAT_SHORT_MS   = 10;
  localparam int REPEAT_LONG_CYC   = REPEAT_LONG_MS * CLK_FREQ_KHZ;
  localparam int REPEAT_SHORT_CYC  = REPEAT_SHORT_MS * CLK_FREQ_KHZ;
  localparam int KEY_WORDS         = 4;

  // ----------------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  page;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cur_nfc_req_s;

  typedef struct packed {
    logic        commission_frame_off;
    logic        rotating_addr_sel;
    logic        comm_on_user;
    logic        data_on_user;
    logic [1:0]  user_chan_cnt;
    logic        rate_2m;
    logic [19:0] repeat_gap;
    logic [2:0]  payload_bytes;
  } cur_radio_s;

  typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_CLEAR} cur_state_e;

endpackage
`default_nettype wire

// *** core/cur_regs.sv ***
// configuration update register bank with actuation-driven commit
//
// Contract
// - config byte: length code 7:6, then comm off, rotating addr, hidden, key/maker/node commit
// - node address staging replaces only low 32 bits; upper 16 fixed type constant
// - actuation with node commit flag copies address then clears the flag
// - actuation with key commit flag copies 16-byte key to store, clears flag
// - forbidden staging key values leave the stored key unchanged
// - hidden key mode shows key as zeros to reader and commissioning frames
// - key store sustains at least 1000 commits; commits are counted
// - maker commit copies non-zero product id and maker code, skips zeros, clears flag
// - length code 00/01/10/11 means 0, 1, 2 or 4 extra bytes
// - extra bytes taken from byte 0 upward and appended to data frames
// - variant byte: plan in bits 2:0, interval and rate next, rest spare
// - repeat gap 20 ms by default, 10 ms when interval bit set
// - air rate 1 Mbit by default, 2 Mbit when rate bit set
// - plan 000 all on advertising; 001-011 data on three, two, one user channels
// - plans 100-110 put all frames on three, two, one user channels
// - reserved plan 111 behaves like plan 000
// - comm off suppresses commissioning frames; rotating addr selects private addressing
// - protected pages locked until reader writes the correct 32-bit pin
// - plans 001-110 take transmit channels from the three bytes of the user channel register
// - variant bit 3 selects the shorter repeat gap
// - variant bit 4 selects the higher air rate
`default_nettype none
module cur_regs
  import cur_pkg::*;
#(
  parameter logic [15:0] DEV_TYPE      = 16'h5a00,      // arbitrary value
  parameter logic [31:0] NODE_DEFAULT  = 32'h0000_0001,
  parameter logic [15:0] MAKER_DEFAULT = 16'h0001,      // arbitrary value
  parameter logic [31:0] PIN_DEFAULT   = 32'h0000_1234, // arbitrary value
  parameter int          LONG_CYC      = cur_pkg::REPEAT_LONG_CYC,
  parameter int          SHORT_CYC     = cur_pkg::REPEAT_SHORT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire cur_pkg::cur_nfc_req_s nfc_req,
  output logic [31:0]               nfc_rdata,
  output logic                      nfc_rvalid,
  output logic                      unlocked,
  input  wire logic                 actuate,
  output logic                      commit_busy,
  output logic [47:0]               node_addr,
  output logic [63:0]               product_id,
  output logic [15:0]               maker_code,
  input  wire logic [1:0]           key_rd_idx,
  output logic [31:0]               key_word,
  output logic [15:0]               key_commits,
  output cur_pkg::cur_radio_s       radio,
  output logic [31:0]               extra_bytes,
  output logic [23:0]               user_chans
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0]   cfg_q;
  logic [7:0]   variant_q;
  logic [31:0]  extra_q;
  logic [63:0]  prod_stg_q;
  logic [31:0]  addr_stg_q;
  logic [15:0]  maker_stg_q;
  logic [127:0] key_stg_q;
  logic [23:0]  chan_q;
  logic [31:0]  pin_q;
  logic         unlocked_q;
  logic         hidden_q;
  logic [31:0]  node_low_q;
  logic [63:0]  prod_q;
  logic [15:0]  maker_q;
  logic [15:0]  commits_q;
  cur_state_e   state_q;
  logic [1:0]   idx_q;
  logic         snap_node_q;
  logic         snap_maker_q;
  logic         snap_key_q;
  logic [31:0]  key_mem_rdata;

  logic         wr;
  logic         prot_page;
  logic         prot_wr;
  logic         cfg_wr;
  logic         key_bad;
  logic         key_we;
  logic         copy_first;
  logic         go;

  assign wr         = nfc_req.wr;
  assign prot_page  = (nfc_req.page >= PG_PROT_FIRST) && (nfc_req.page != PG_PIN);
  // protected writes need the pin and are held off while a commit runs
  assign prot_wr    = wr && prot_page && unlocked_q && (state_q == ST_IDLE);
  assign cfg_wr     = prot_wr && (nfc_req.page == PG_CFG_VARIANT);
  assign key_bad    = (key_stg_q == '0) || (key_stg_q == '1);
  assign key_we     = (state_q == ST_COPY) && snap_key_q && !key_bad;
  assign copy_first = (state_q == ST_COPY) && (idx_q == 2'd0);
  assign go         = (state_q == ST_IDLE) && actuate;

  // ----------------------------------------------------------------------
  // pin unlock
  // ----------------------------------------------------------------------
  // first matching pin write unlocks, later pin writes replace the pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlocked_q <= 1'b0;
      pin_q      <= PIN_DEFAULT;
    end else if (wr && nfc_req.page == PG_PIN) begin
      if (!unlocked_q) begin
        unlocked_q <= (nfc_req.wdata == pin_q);
      end else begin
        pin_q <= nfc_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // config and variant
  // ----------------------------------------------------------------------
  // hardware clear of commit flags wins; reader writes are dropped while a commit runs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q     <= CFG_RESET;
      variant_q <= VARIANT_RESET;
    end else if (cfg_wr) begin
      cfg_q     <= nfc_req.wdata[7:0];
      variant_q <= nfc_req.wdata[15:8];
    end else if (state_q == ST_CLEAR) begin
      if (snap_node_q) begin
        cfg_q[CFG_NODE_COMMIT] <= 1'b0;
      end
      if (snap_maker_q) begin
        cfg_q[CFG_MAKER_COMMIT] <= 1'b0;
      end
      if (snap_key_q && !key_bad) begin
        cfg_q[CFG_KEY_COMMIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // staging registers
  // ----------------------------------------------------------------------
  // plain reader-written staging words
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extra_q     <= WORD_RESET;
      prod_stg_q  <= '0;
      addr_stg_q  <= WORD_RESET;
      maker_stg_q <= '0;
      key_stg_q   <= '0;
      chan_q      <= '0;
    end else if (prot_wr) begin
      unique case (nfc_req.page)
        PG_EXTRA_DATA:  extra_q            <= nfc_req.wdata;
        PG_PROD_STG_LO: prod_stg_q[31:0]   <= nfc_req.wdata;
        PG_PROD_STG_HI: prod_stg_q[63:32]  <= nfc_req.wdata;
        PG_ADDR_STG:    addr_stg_q         <= nfc_req.wdata;
        PG_MAKER_STG:   maker_stg_q        <= nfc_req.wdata[15:0];
        PG_USER_CHAN:   chan_q             <= nfc_req.wdata[23:0];
        default: begin
          if (nfc_req.page >= PG_KEY_STG_0 && nfc_req.page <= PG_KEY_STG_3) begin
            key_stg_q[32*(nfc_req.page[1:0]) +: 32] <= nfc_req.wdata;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // commit sequencer
  // ----------------------------------------------------------------------
  // snapshot flags on actuation, walk the key words, then clear flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= ST_IDLE;
      idx_q        <= 2'd0;
      snap_node_q  <= 1'b0;
      snap_maker_q <= 1'b0;
      snap_key_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          idx_q <= 2'd0;
          if (actuate) begin
            state_q      <= ST_COPY;
            snap_node_q  <= cfg_q[CFG_NODE_COMMIT];
            snap_maker_q <= cfg_q[CFG_MAKER_COMMIT];
            snap_key_q   <= cfg_q[CFG_KEY_COMMIT];
          end
        end
        ST_COPY: begin
          idx_q <= idx_q + 2'd1;
          if (idx_q == 2'(KEY_WORDS - 1)) begin
            state_q <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // live identity
  // ----------------------------------------------------------------------
  // node address and maker fields copied on the first copy cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      node_low_q <= NODE_DEFAULT;
      prod_q     <= '0;
      maker_q    <= MAKER_DEFAULT;
    end else if (copy_first) begin
      if (snap_node_q) begin
        node_low_q <= addr_stg_q;
      end
      if (snap_maker_q && prod_stg_q != '0) begin
        prod_q <= prod_stg_q;
      end
      if (snap_maker_q && maker_stg_q != '0) begin
        maker_q <= maker_stg_q;
      end
    end
  end

  // hidden mode latched and commits counted when a key lands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hidden_q  <= 1'b0;
      commits_q <= '0;
    end else if (state_q == ST_CLEAR && snap_key_q && !key_bad) begin
      hidden_q <= cfg_q[CFG_KEY_HIDDEN];
      if (commits_q != '1) begin
        commits_q <= commits_q + 16'd1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // key store
  // ----------------------------------------------------------------------
  cur_key_mem #(
    .WORDS (KEY_WORDS),
    .WIDTH (32)
  ) u_key_mem (
    .clk   (clk),
    .we    (key_we),
    .waddr (idx_q),
    .wdata (key_stg_q[32*idx_q +: 32]),
    .raddr (key_rd_idx),
    .rdata (key_mem_rdata)
  );

  // ----------------------------------------------------------------------
  // reader answers
  // ----------------------------------------------------------------------
  // one cycle read answer; locked protected pages read as zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nfc_rdata  <= WORD_RESET;
      nfc_rvalid <= 1'b0;
    end else begin
      nfc_rvalid <= nfc_req.rd;
      nfc_rdata  <= WORD_RESET;
      if (nfc_req.rd && (!prot_page || unlocked_q)) begin
        unique case (nfc_req.page)
          PG_PROD_ID_LO:  nfc_rdata <= prod_q[31:0];
          PG_PROD_ID_HI:  nfc_rdata <= prod_q[63:32];
          PG_MAKER:       nfc_rdata <= {16'h0000, maker_q};
          PG_NODE_ADDR:   nfc_rdata <= node_low_q;
          PG_CFG_VARIANT: nfc_rdata <= {16'h0000, variant_q, cfg_q};
          PG_EXTRA_DATA:  nfc_rdata <= extra_q;
          PG_PROD_STG_LO: nfc_rdata <= prod_stg_q[31:0];
          PG_PROD_STG_HI: nfc_rdata <= prod_stg_q[63:32];
          PG_ADDR_STG:    nfc_rdata <= addr_stg_q;
          PG_MAKER_STG:   nfc_rdata <= {16'h0000, maker_stg_q};
          PG_USER_CHAN:   nfc_rdata <= {8'h00, chan_q};
          default: begin
            if (nfc_req.page >= PG_KEY_STG_0 && nfc_req.page <= PG_KEY_STG_3
                && !hidden_q) begin
              nfc_rdata <= key_stg_q[32*(nfc_req.page[1:0]) +: 32];
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // identity outputs
  // ----------------------------------------------------------------------
  // registered copies of live identity and masked key word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      node_addr   <= '0;
      product_id  <= '0;
      maker_code  <= '0;
      key_word    <= '0;
      key_commits <= '0;
      unlocked    <= 1'b0;
      commit_busy <= 1'b0;
    end else begin
      node_addr   <= {DEV_TYPE, node_low_q};
      product_id  <= prod_q;
      maker_code  <= maker_q;
      key_word    <= hidden_q ? '0 : key_mem_rdata;
      key_commits <= commits_q;
      unlocked    <= unlocked_q;
      commit_busy <= (state_q != ST_IDLE) || go;
    end
  end

  // ----------------------------------------------------------------------
  // radio settings
  // ----------------------------------------------------------------------
  // decode variant and config into frame settings
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      radio       <= '0;
      extra_bytes <= '0;
      user_chans  <= '0;
    end else begin
      radio.commission_frame_off <= cfg_q[CFG_COMM_OFF];
      radio.rotating_addr_sel    <= cfg_q[CFG_ROTATING_ADDR];
      radio.rate_2m              <= variant_q[VAR_RATE];
      radio.repeat_gap <= variant_q[VAR_INTERVAL] ? 20'(SHORT_CYC)
                                                  : 20'(LONG_CYC);
      unique case (cfg_q[CFG_LEN_LSB +: 2])
        2'b00: begin
          radio.payload_bytes <= 3'd0;
          extra_bytes         <= '0;
        end
        2'b01: begin
          radio.payload_bytes <= 3'd1;
          extra_bytes         <= {24'h000000, extra_q[7:0]};
        end
        2'b10: begin
          radio.payload_bytes <= 3'd2;
          extra_bytes         <= {16'h0000, extra_q[15:0]};
        end
        2'b11: begin
          radio.payload_bytes <= 3'd4;
          extra_bytes         <= extra_q;
        end
      endcase
      unique case (variant_q[VAR_PLAN_LSB +: 3])
        3'b001, 3'b010, 3'b011: begin
          radio.comm_on_user  <= 1'b0;
          radio.data_on_user  <= 1'b1;
          radio.user_chan_cnt <= 2'd3 - (variant_q[1:0] - 2'd1);
        end
        3'b100, 3'b101, 3'b110: begin
          radio.comm_on_user  <= 1'b1;
          radio.data_on_user  <= 1'b1;
          radio.user_chan_cnt <= 2'd3 - variant_q[1:0];
        end
        default: begin
          radio.comm_on_user  <= 1'b0;
          radio.data_on_user  <= 1'b0;
          radio.user_chan_cnt <= 2'd0;
        end
      endcase
      user_chans <= (variant_q[2:0] == 3'b000 || variant_q[2:0] == 3'b111)
                    ? 24'h000000 : chan_q;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_node_copy: assert property (@(posedge clk) disable iff (!rst_b)
    copy_first && snap_node_q |=> node_low_q == $past(addr_stg_q))
    else $error("node address not copied");

  chk_upper_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    $past(rst_b) |-> node_addr[47:32] == DEV_TYPE)
    else $error("node address upper bits changed");

  chk_flag_clear: assert property (@(posedge clk) disable iff (!rst_b)
    go && cfg_q[CFG_NODE_COMMIT] && !cfg_wr ##1 !cfg_wr [*5]
    |=> !cfg_q[CFG_NODE_COMMIT])
    else $error("node commit flag not cleared");

  chk_key_walk: assert property (@(posedge clk) disable iff (!rst_b)
    go && cfg_q[CFG_KEY_COMMIT] && !key_bad |=> key_we [*4] ##1 !key_we)
    else $error("key copy not four words");

  chk_bad_key: assert property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_CLEAR && snap_key_q && key_bad
    |=> cfg_q[CFG_KEY_COMMIT] && $stable(commits_q))
    else $error("forbidden key committed");

  chk_hidden_read: assert property (@(posedge clk) disable iff (!rst_b)
    hidden_q && nfc_req.rd && nfc_req.page == PG_KEY_STG_0 |=> nfc_rdata == '0)
    else $error("hidden key exposed");

  chk_maker_skip: assert property (@(posedge clk) disable iff (!rst_b)
    copy_first && maker_stg_q == '0 |=> $stable(maker_q))
    else $error("zero maker code committed");

  chk_len_four: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_q[7:6] == 2'b11 |=> radio.payload_bytes == 3'd4 && extra_bytes == $past(extra_q))
    else $error("length code 11 not four bytes");

  chk_short_gap: assert property (@(posedge clk) disable iff (!rst_b)
    variant_q[VAR_INTERVAL] |=> radio.repeat_gap == 20'(SHORT_CYC))
    else $error("short repeat gap wrong");

  chk_plan_spare: assert property (@(posedge clk) disable iff (!rst_b)
    variant_q[2:0] == 3'b111 |=> !radio.data_on_user && !radio.comm_on_user)
    else $error("reserved plan not default");

  chk_locked_write: assert property (@(posedge clk) disable iff (!rst_b)
    !unlocked_q && wr && nfc_req.page == PG_CFG_VARIANT && state_q == ST_IDLE
    |=> cfg_q == $past(cfg_q))
    else $error("locked config written");

endmodule // cur_regs
`default_nettype wire

// *** verif/cur_reader.sv ***
// reader model: pin unlock, staging and flag writes, page reads
`default_nettype none
module cur_reader (
  input  wire logic                  clk,
  input  wire logic [31:0]           rdata,
  input  wire logic                  rvalid,
  output var  cur_pkg::cur_nfc_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // one write strobe; bench tries one locked flag write, then orders pin, staging, then flags
  task automatic wr(input logic [7:0] pg, input logic [31:0] d);
    @(posedge clk);
    #1;
    req = '{page: pg, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    #1;
    req.wr = 1'b0;
    req.wdata = ~d; // released data no longer shows the value
  endtask
  // one read strobe, answer taken in the following cycle
  task automatic rd(input logic [7:0] pg, output logic [31:0] d);
    @(posedge clk);
    #1;
    req.page = pg;
    req.rd = 1'b1;
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    d = (rvalid === 1'b1) ? rdata : 32'hdead_beef;
  endtask
endmodule // cur_reader
`default_nettype wire

// *** verif/test_cur_regs.sv ***
// self-checking bench of the configuration update register bank
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_cur_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import cur_pkg::*;
  logic clk = 0, rst_b = 0, actuate = 0, nfc_rvalid, unlocked, commit_busy;
  logic [1:0] key_rd_idx = 0;
  cur_nfc_req_s nfc_req;
  cur_radio_s radio, er;
  logic [31:0] nfc_rdata, extra_bytes, key_word, r, a, x;
  logic [47:0] node_addr;
  logic [63:0] product_id, p;
  logic [15:0] maker_code, key_commits, m;
  logic [23:0] user_chans, ch;
  logic [127:0] k;
  logic [7:0] c, v;
  int fail_count = 0, compares = 0, cyc = 0;
  cur_regs #(.LONG_CYC(200), .SHORT_CYC(100)) dut (.clk(clk), .rst_b(rst_b),
    .nfc_req(nfc_req), .nfc_rdata(nfc_rdata), .nfc_rvalid(nfc_rvalid), .unlocked(unlocked),
    .actuate(actuate), .commit_busy(commit_busy), .node_addr(node_addr),
    .product_id(product_id), .maker_code(maker_code), .key_rd_idx(key_rd_idx),
    .key_word(key_word), .key_commits(key_commits), .radio(radio),
    .extra_bytes(extra_bytes), .user_chans(user_chans));
  cur_reader rdr (.clk(clk), .rdata(nfc_rdata), .rvalid(nfc_rvalid), .req(nfc_req));
  // clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // actuation pulse, then bounded wait for the sequence to end
  task automatic press();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    actuate = 1;
    @(posedge clk);
    #1;
    actuate = 0;
    `CHK(commit_busy, 1'b1)
    while (commit_busy === 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic wkey(input logic [127:0] kk);
    for (int i = 0; i < 4; i++) rdr.wr(PG_KEY_STG_0 + 8'(i), kk[32*i+:32]);
  endtask
  // expected radio settings from config and variant bytes
  function automatic cur_radio_s exp_radio(input logic [7:0] cf, input logic [7:0] vr);
    cur_radio_s e;
    e.commission_frame_off = cf[5];
    e.rotating_addr_sel = cf[4];
    e.data_on_user = vr[2:0] != 3'h0 && vr[2:0] != 3'h7;
    e.comm_on_user = vr[2] && vr[2:0] != 3'h7;
    e.user_chan_cnt = e.data_on_user ? 2'(3 - (vr[2:0] - 3'h1) % 3) : 2'h0;
    e.rate_2m = vr[4];
    e.repeat_gap = vr[3] ? 20'h64 : 20'hc8;
    e.payload_bytes = (cf[7:6] == 2'h3) ? 3'h4 : {1'b0, cf[7:6]};
    return e;
  endfunction
  initial begin
    void'($urandom(32'h7361));
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1;
    @(posedge clk);
    #1;
    `CHK(node_addr, {16'h5a00, 32'h1})
    rdr.wr(PG_CFG_VARIANT, 32'h0000_00ff);
    rdr.rd(PG_CFG_VARIANT, r);
    `CHK(r, 32'h0)
    rdr.wr(PG_PIN, 32'h0000_1234);
    rdr.rd(PG_CFG_VARIANT, r);
    `CHK(unlocked, 1'b1)
    `CHK(r, 32'h0)
    a = $urandom;
    p = {$urandom, $urandom};
    rdr.wr(PG_ADDR_STG, a);
    rdr.wr(PG_PROD_STG_LO, p[31:0]);
    rdr.wr(PG_PROD_STG_HI, p[63:32]);
    rdr.wr(PG_MAKER_STG, 32'h0);
    wkey('1);
    rdr.wr(PG_CFG_VARIANT, 32'h07);
    press();
    `CHK(node_addr, {16'h5a00, a})
    `CHK(product_id, p)
    `CHK(maker_code, 16'h1)
    `CHK(key_commits, 16'h0)
    rdr.rd(PG_CFG_VARIANT, r);
    `CHK(r, 32'h04)
    m = 16'($urandom) | 16'h1;
    rdr.wr(PG_PROD_STG_LO, 32'h0);
    rdr.wr(PG_PROD_STG_HI, 32'h0);
    rdr.wr(PG_MAKER_STG, {16'h0, m});
    rdr.wr(PG_CFG_VARIANT, 32'h02);
    press();
    `CHK(product_id, p)
    `CHK(maker_code, m)
    k = {$urandom, $urandom, $urandom, $urandom};
    wkey(k);
    rdr.wr(PG_CFG_VARIANT, 32'h0c);
    press();
    `CHK(key_commits, 16'h1)
    `CHK(key_word, 32'h0)
    rdr.rd(PG_KEY_STG_0, r);
    `CHK(r, 32'h0)
    k = {$urandom, $urandom, $urandom, $urandom};
    wkey(k);
    rdr.wr(PG_CFG_VARIANT, 32'h04);
    press();
    `CHK(key_commits, 16'h2)
    for (int i = 0; i < 4; i++) begin
      key_rd_idx = 2'(i);
      repeat (3) @(posedge clk);
      #1;
      `CHK(key_word, k[32*i+:32])
    end
    ch = 24'($urandom);
    rdr.wr(PG_USER_CHAN, {8'h0, ch});
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom);
      if (i < 8) v[2:0] = 3'(i);
      c = {5'($urandom), 3'h0};
      x = $urandom;
      rdr.wr(PG_EXTRA_DATA, x);
      rdr.wr(PG_CFG_VARIANT, {16'h0, v, c});
      repeat (3) @(posedge clk);
      #1;
      er = exp_radio(c, v);
      `CHK(radio, er)
      `CHK(extra_bytes, x & 32'((64'h1 << (8 * er.payload_bytes)) - 1))
      `CHK(user_chans, er.data_on_user ? ch : 24'h0)
    end
    tally_and_finish();
  end
endmodule // test_cur_regs
`default_nettype wire
